/* axc_cfg.svh */
// Summary of operation
// - Instruction 33 combines accumulator with X register, result back into accumulator.
// - Types 0..4 select add, subtract X, multiply, divide, remainder of accumulator by X.
// - Types 5..8 select AND, OR, XOR with X, and inversion of X.
// - Type 9 copies the accumulator into the X register.
// - Type 10 exchanges accumulator and X register in one step.
// - Instruction 34 writes accumulator into the axis parameter of the selected motor.
// - Instruction 35 writes accumulator into a global parameter; banks 0, 2, 3 only.
// - Instruction 36 clears selected error flags, accumulator and other flags untouched.
// - Flag selector: 0 all, 1 timeout, 2 alarm, 3 deviation, 4 position, 5 shutdown.
// - In direct mode each command is answered with a status, 100 on success and 1..4 on a fault; value carries nothing.
`ifndef AXC_CFG_SVH
`define AXC_CFG_SVH

`define AXC_FRAME_LAST 4'h8

`define AXC_INS_XREG_MATH 8'h21
`define AXC_INS_TO_AXIS 8'h22
`define AXC_INS_TO_GLOBAL 8'h23
`define AXC_INS_CLEAR_ERR 8'h24

`define AXC_OP_ADD 8'h00
`define AXC_OP_SUB 8'h01
`define AXC_OP_PROD 8'h02
`define AXC_OP_DIV 8'h03
`define AXC_OP_REM 8'h04
`define AXC_OP_AND 8'h05
`define AXC_OP_OR 8'h06
`define AXC_OP_XOR 8'h07
`define AXC_OP_NOT 8'h08
`define AXC_OP_LOAD 8'h09
`define AXC_OP_SWAP 8'h0a

`define AXC_CLR_ALL 8'h00
`define AXC_CLR_LAST 8'h05
`define AXC_NUM_FLAGS 5

`define AXC_GBANK_A 8'h00
`define AXC_GBANK_B 8'h02
`define AXC_GBANK_C 8'h03
`define AXC_NUM_MOTORS 8'h01

`define AXC_ST_OK 8'h64
`define AXC_ST_BAD_CSUM 8'h01
`define AXC_ST_BAD_CMD 8'h02
`define AXC_ST_BAD_TYPE 8'h03
`define AXC_ST_BAD_VALUE 8'h04

`define AXC_MEM_AW 10
`define AXC_MEM_DEPTH 1024

`define AXC_REG_ACCU 8'h00
`define AXC_REG_XREG 8'h04
`define AXC_REG_ERRFLAGS 8'h08
`define AXC_REG_IRQ_STATUS 8'h0c
`define AXC_REG_IRQ_CLEAR 8'h10
`define AXC_REG_IRQ_ENABLE 8'h14
`define AXC_REG_PARAM_ADDR 8'h18
`define AXC_REG_PARAM_DATA 8'h1c
`define AXC_REG_CTRL 8'h20

`define AXC_CTRL_DIRECT_BIT 0
`define AXC_CTRL_ADDR_LSB 8
`define AXC_CTRL_RESET 32'h0000_0101

`define AXC_EV_DONE 0
`define AXC_EV_CSUM 1
`define AXC_EV_REJECT 2
`define AXC_EV_FLAG 3
`define AXC_NUM_EV 4

`endif

/* axc_pkg.sv */
`include "axc_cfg.svh"
package axc_pkg;
   typedef logic [7:0] axc_byte_t;
   typedef logic signed [31:0] axc_word_t;
   typedef logic [3:0] axc_count_t;
   typedef logic [`AXC_MEM_AW-1:0] axc_maddr_t;
endpackage

/* axc_param_mem.sv */
`timescale 1ns/100ps
`include "axc_cfg.svh"
module axc_param_mem (
   input wire logic mclk,
   input wire logic ce,
   input wire logic wr_en,
   input wire axc_pkg::axc_maddr_t wr_addr,
   input wire axc_pkg::axc_word_t wr_data,
   input wire axc_pkg::axc_maddr_t rd_addr,
   output axc_pkg::axc_word_t rd_data_q
);
   axc_pkg::axc_word_t mem [0:`AXC_MEM_DEPTH-1];

   // No reset on the array so it maps onto block memory; contents start undefined.
   always_ff @(posedge mclk) begin
      if (ce && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // A read of the address being written returns the old word.
   always_ff @(posedge mclk) begin
      if (ce) begin
         rd_data_q <= mem[rd_addr];
      end
   end
endmodule

/* axc_top.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "axc_cfg.svh"
module axc_top (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata_q,
   input wire logic rx_valid,
   input wire axc_pkg::axc_byte_t rx_byte,
   input wire logic [`AXC_NUM_FLAGS-1:0] flag_set,
   output logic rsp_valid_q,
   output axc_pkg::axc_byte_t rsp_module_q,
   output axc_pkg::axc_byte_t rsp_status_q,
   output axc_pkg::axc_byte_t rsp_instr_q,
   output axc_pkg::axc_word_t rsp_value_q,
   output logic [`AXC_NUM_FLAGS-1:0] err_flags_q,
   output axc_pkg::axc_word_t accu_q,
   output logic irq_q
);
   axc_pkg::axc_count_t cnt_q;
   axc_pkg::axc_byte_t sum_q;
   axc_pkg::axc_byte_t f_addr_q;
   axc_pkg::axc_byte_t f_ins_q;
   axc_pkg::axc_byte_t f_type_q;
   axc_pkg::axc_byte_t f_bank_q;
   axc_pkg::axc_word_t f_val_q;
   logic f_csum_ok_q;
   logic exec_q;
   axc_pkg::axc_word_t xreg_q;
   logic [`AXC_NUM_EV-1:0] irq_status_q;
   logic [`AXC_NUM_EV-1:0] irq_status_d;
   logic [`AXC_NUM_EV-1:0] irq_enable_q;
   axc_pkg::axc_maddr_t param_addr_q;
   logic [31:0] ctrl_q;
   axc_pkg::axc_word_t mem_rd_data;

   logic hit;
   logic bus_wr_accu;
   logic bus_wr_xreg;
   axc_pkg::axc_byte_t st_d;
   logic accu_we;
   axc_pkg::axc_word_t accu_d;
   logic xreg_we;
   axc_pkg::axc_word_t xreg_d;
   logic [`AXC_NUM_FLAGS-1:0] flag_clr;
   logic mem_we;
   axc_pkg::axc_maddr_t mem_waddr;
   logic [`AXC_NUM_EV-1:0] ev;
   logic [`AXC_NUM_EV-1:0] irq_clr;

   // Signed arithmetic and logic between accumulator and X register.
   function automatic axc_pkg::axc_word_t xreg_math(input axc_pkg::axc_byte_t op,
      input axc_pkg::axc_word_t a,
      input axc_pkg::axc_word_t x);
      axc_pkg::axc_word_t r;
      r = a;
      unique case (op)
         `AXC_OP_ADD: r = a + x;
         `AXC_OP_SUB: r = a - x;
         `AXC_OP_PROD: r = a * x;
         `AXC_OP_DIV: r = a / x;
         `AXC_OP_REM: r = a % x;
         `AXC_OP_AND: r = a & x;
         `AXC_OP_OR: r = a | x;
         `AXC_OP_XOR: r = a ^ x;
         `AXC_OP_NOT: r = ~x;
         default: r = a;
      endcase
      return r;
   endfunction

   // Frame collector; bytes are counted from reset, so a lost byte shifts every later frame.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 4'h0;
         sum_q <= 8'h00;
      end else if (ce && rx_valid) begin
         if (cnt_q == `AXC_FRAME_LAST) begin
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 4'h1;
            sum_q <= sum_q + rx_byte;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         f_addr_q <= 8'h00;
         f_ins_q <= 8'h00;
         f_type_q <= 8'h00;
         f_bank_q <= 8'h00;
         f_val_q <= 32'h0000_0000;
         f_csum_ok_q <= 1'b0;
      end else if (ce && rx_valid) begin
         unique case (cnt_q)
            4'h0: f_addr_q <= rx_byte;
            4'h1: f_ins_q <= rx_byte;
            4'h2: f_type_q <= rx_byte;
            4'h3: f_bank_q <= rx_byte;
            4'h8: f_csum_ok_q <= (rx_byte == sum_q);
            default: f_val_q <= {f_val_q[23:0], rx_byte};
         endcase
      end
   end

   // Only frames for this module are executed; others pass silently.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         exec_q <= 1'b0;
      end else if (ce) begin
         exec_q <= rx_valid && (cnt_q == `AXC_FRAME_LAST) &&
                   (f_addr_q == ctrl_q[`AXC_CTRL_ADDR_LSB +: 8]);
      end
   end

   // Command decode and execution, one cycle after the checksum byte.
   always_comb begin
      st_d = `AXC_ST_OK;
      accu_we = 1'b0;
      accu_d = accu_q;
      xreg_we = 1'b0;
      xreg_d = xreg_q;
      flag_clr = '0;
      mem_we = 1'b0;
      mem_waddr = {2'b00, f_type_q};
      if (!f_csum_ok_q) begin
         st_d = `AXC_ST_BAD_CSUM;
      end else begin
         unique case (f_ins_q)
            `AXC_INS_XREG_MATH: begin
               // Bank and value bytes play no part here.
               if (f_type_q > `AXC_OP_SWAP) begin
                  st_d = `AXC_ST_BAD_TYPE;
               end else if (f_type_q == `AXC_OP_LOAD) begin
                  xreg_we = 1'b1;
                  xreg_d = accu_q;
               end else if (f_type_q == `AXC_OP_SWAP) begin
                  accu_we = 1'b1;
                  accu_d = xreg_q;
                  xreg_we = 1'b1;
                  xreg_d = accu_q;
               end else if ((f_type_q == `AXC_OP_DIV || f_type_q == `AXC_OP_REM) &&
                            xreg_q == 32'sh0000_0000) begin
                  // Division by zero leaves the accumulator alone rather than trashing it.
                  st_d = `AXC_ST_BAD_VALUE;
               end else begin
                  accu_we = 1'b1;
                  accu_d = xreg_math(f_type_q, accu_q, xreg_q);
               end
            end
            `AXC_INS_TO_AXIS: begin
               if (f_bank_q >= `AXC_NUM_MOTORS) begin
                  st_d = `AXC_ST_BAD_VALUE;
               end else begin
                  mem_we = 1'b1;
                  mem_waddr = {2'b00, f_type_q};
               end
            end
            `AXC_INS_TO_GLOBAL: begin
               mem_we = 1'b1;
               unique case (f_bank_q)
                  `AXC_GBANK_A: mem_waddr = {2'b01, f_type_q};
                  `AXC_GBANK_B: mem_waddr = {2'b10, f_type_q};
                  `AXC_GBANK_C: mem_waddr = {2'b11, f_type_q};
                  default: begin
                     mem_we = 1'b0;
                     st_d = `AXC_ST_BAD_VALUE;
                  end
               endcase
            end
            `AXC_INS_CLEAR_ERR: begin
               if (f_type_q > `AXC_CLR_LAST) begin
                  st_d = `AXC_ST_BAD_TYPE;
               end else if (f_type_q == `AXC_CLR_ALL) begin
                  flag_clr = '1;
               end else begin
                  flag_clr[f_type_q[2:0] - 3'd1] = 1'b1;
               end
            end
            default: st_d = `AXC_ST_BAD_CMD;
         endcase
      end
      if (!exec_q) begin
         accu_we = 1'b0;
         xreg_we = 1'b0;
         flag_clr = '0;
         mem_we = 1'b0;
      end
   end

   always_comb begin
      bus_wr_accu = bus_wr && (bus_addr == `AXC_REG_ACCU);
      bus_wr_xreg = bus_wr && (bus_addr == `AXC_REG_XREG);
      hit = bus_wr && (bus_addr == `AXC_REG_IRQ_CLEAR);
      irq_clr = hit ? bus_wdata[`AXC_NUM_EV-1:0] : '0;
      ev = '0;
      ev[`AXC_EV_DONE] = exec_q && (st_d == `AXC_ST_OK);
      ev[`AXC_EV_CSUM] = exec_q && (st_d == `AXC_ST_BAD_CSUM);
      ev[`AXC_EV_REJECT] = exec_q && (st_d != `AXC_ST_OK) && (st_d != `AXC_ST_BAD_CSUM);
      ev[`AXC_EV_FLAG] = |flag_set;
      // A new event wins over a clear in the same cycle.
      irq_status_d = (irq_status_q & ~irq_clr) | ev;
   end

   // Commands take priority over a software write in the same cycle.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         accu_q <= 32'h0000_0000;
      end else if (ce) begin
         if (accu_we) begin
            accu_q <= accu_d;
         end else if (bus_wr_accu) begin
            accu_q <= bus_wdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         xreg_q <= 32'h0000_0000;
      end else if (ce) begin
         if (xreg_we) begin
            xreg_q <= xreg_d;
         end else if (bus_wr_xreg) begin
            xreg_q <= bus_wdata;
         end
      end
   end

   // Error flags: raised by the motion core, cleared by command; raising wins.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         err_flags_q <= '0;
      end else if (ce) begin
         err_flags_q <= (err_flags_q & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_status_q <= '0;
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_status_q <= irq_status_d;
         irq_q <= |(irq_status_d & irq_enable_q);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_enable_q <= '0;
         param_addr_q <= '0;
         ctrl_q <= `AXC_CTRL_RESET;
      end else if (ce && bus_wr) begin
         unique case (bus_addr)
            `AXC_REG_IRQ_ENABLE: irq_enable_q <= bus_wdata[`AXC_NUM_EV-1:0];
            `AXC_REG_PARAM_ADDR: param_addr_q <= bus_wdata[`AXC_MEM_AW-1:0];
            `AXC_REG_CTRL: ctrl_q <= {16'h0000, bus_wdata[15:8], 7'h00, bus_wdata[0]};
            default: ;
         endcase
      end
   end

   // Reply only in direct mode; the value field is left at zero.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_module_q <= 8'h00;
         rsp_status_q <= 8'h00;
         rsp_instr_q <= 8'h00;
         rsp_value_q <= 32'h0000_0000;
      end else if (ce) begin
         rsp_valid_q <= exec_q && ctrl_q[`AXC_CTRL_DIRECT_BIT];
         if (exec_q) begin
            rsp_module_q <= ctrl_q[`AXC_CTRL_ADDR_LSB +: 8];
            rsp_status_q <= st_d;
            rsp_instr_q <= f_ins_q;
            rsp_value_q <= 32'h0000_0000;
         end
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         bus_rdata_q <= 32'h0000_0000;
         if (bus_rd) begin
            unique case (bus_addr)
               `AXC_REG_ACCU: bus_rdata_q <= accu_q;
               `AXC_REG_XREG: bus_rdata_q <= xreg_q;
               `AXC_REG_ERRFLAGS: bus_rdata_q <= {27'h0, err_flags_q};
               `AXC_REG_IRQ_STATUS: bus_rdata_q <= {28'h0, irq_status_q};
               `AXC_REG_IRQ_ENABLE: bus_rdata_q <= {28'h0, irq_enable_q};
               `AXC_REG_PARAM_ADDR: bus_rdata_q <= {22'h0, param_addr_q};
               `AXC_REG_PARAM_DATA: bus_rdata_q <= mem_rd_data;
               `AXC_REG_CTRL: bus_rdata_q <= ctrl_q;
               default: bus_rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Parameter store: axis bank then global banks 0, 2 and 3, 256 words each.
   axc_param_mem u_mem (
      .mclk(mclk),
      .ce(ce),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(accu_q),
      .rd_addr(param_addr_q),
      .rd_data_q(mem_rd_data)
   );
endmodule

/* axc_host_model.sv */
`timescale 1ns/100ps
module axc_host_model (
   input wire logic mclk,
   output logic rx_valid,
   output axc_pkg::axc_byte_t rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
   // A set bad bit spoils the checksum so that a refused frame can be commanded.
   task automatic send(input axc_pkg::axc_byte_t a, i, t, b, input axc_pkg::axc_word_t v,
                       input logic bad);
      axc_pkg::axc_byte_t f[9] = '{a, i, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      f[8] = f.sum() + {7'h00, bad};
      for (int k = 0; k < 9; k++) begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_byte <= f[k];
      end
      @(posedge mclk);
      rx_valid <= 1'b0;
      // The idle line shows the inverse of the last byte, never a stale copy.
      rx_byte <= ~f[8];
   endtask
endmodule

/* axc_top_asserts.sv */
`timescale 1ns/100ps
`include "axc_cfg.svh"
module axc_top_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic rx_valid,
   input wire axc_pkg::axc_byte_t rx_byte,
   input wire logic [`AXC_NUM_FLAGS-1:0] flag_set,
   input wire logic rsp_valid_q,
   input wire axc_pkg::axc_byte_t rsp_status_q,
   input wire axc_pkg::axc_byte_t rsp_instr_q,
   input wire axc_pkg::axc_word_t rsp_value_q,
   input wire logic [`AXC_NUM_FLAGS-1:0] err_flags_q,
   input wire axc_pkg::axc_word_t accu_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [3:0] cnt_q;
   logic [7:0] sum_q, ins_q, typ_q;
   logic done_q, ok_q;
   // The checker frames the byte stream itself; done_q marks the exec cycle.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {cnt_q, sum_q, ins_q, typ_q, done_q, ok_q} <= '0;
      end else begin
         done_q <= 1'b0;
         if (ce && rx_valid) begin
            cnt_q <= (cnt_q == `AXC_FRAME_LAST) ? 4'h0 : cnt_q + 4'h1;
            sum_q <= (cnt_q == 4'h0) ? rx_byte : sum_q + rx_byte;
            if (cnt_q == 4'h1) ins_q <= rx_byte;
            if (cnt_q == 4'h2) typ_q <= rx_byte;
            if (cnt_q == `AXC_FRAME_LAST) begin
               done_q <= 1'b1;
               ok_q <= (sum_q == rx_byte);
            end
         end
      end
   end
   property p_accu_src;
      !$stable(accu_q) |-> $past(done_q) || ($past(bus_wr) && $past(bus_addr) == 8'h00);
   endproperty
   a_accu_src: assert property (p_accu_src) else $error("accumulator changed without cause");
   property p_cle_bit;
      done_q && ins_q == 8'h24 && typ_q inside {[8'h01:8'h05]} && flag_set == 5'h00
      ##1 rsp_valid_q && rsp_status_q == 8'h64
      |-> err_flags_q == ($past(err_flags_q) & ~(5'h01 << (typ_q - 8'h01)));
   endproperty
   a_cle_bit: assert property (p_cle_bit) else $error("single flag clear wrong");
   property p_cle_all;
      done_q && ins_q == 8'h24 && typ_q == 8'h00 && flag_set == 5'h00
      ##1 rsp_valid_q && rsp_status_q == 8'h64 |-> err_flags_q == 5'h00;
   endproperty
   a_cle_all: assert property (p_cle_all) else $error("clear of all flags wrong");
   property p_keep_accu;
      done_q && (ins_q inside {8'h22, 8'h23, 8'h24} || (ins_q == 8'h21 && typ_q == 8'h09))
      ##1 rsp_valid_q |-> $stable(accu_q);
   endproperty
   a_keep_accu: assert property (p_keep_accu) else $error("accumulator disturbed");
   property p_ok_frame;
      rsp_valid_q && rsp_status_q == 8'h64
      |-> $past(ok_q) && rsp_instr_q == $past(ins_q) && rsp_value_q == 32'h0;
   endproperty
   a_ok_frame: assert property (p_ok_frame) else $error("good reply for bad frame");
   property p_bad_sum;
      rsp_valid_q && !$past(ok_q) |-> rsp_status_q == `AXC_ST_BAD_CSUM;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("checksum fault not reported");
   property p_reply_time;
      rsp_valid_q |-> $past(done_q);
   endproperty
   a_reply_time: assert property (p_reply_time) else $error("reply at wrong time");
   property p_pulse;
      rsp_valid_q |=> !rsp_valid_q;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reply longer than one cycle");
   property p_flags_fall;
      |($past(err_flags_q) & ~err_flags_q) |-> $past(done_q) && $past(ins_q) == 8'h24;
   endproperty
   a_flags_fall: assert property (p_flags_fall) else $error("flag cleared without command");
   c_ok: cover property (rsp_valid_q && rsp_status_q == 8'h64);
   c_bad: cover property (rsp_valid_q && rsp_status_q == `AXC_ST_BAD_CSUM);
   c_cle: cover property (done_q && ins_q == 8'h24);
endmodule
bind axc_top axc_top_chk chk_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus_addr(bus_addr),
   .bus_wr(bus_wr), .rx_valid(rx_valid), .rx_byte(rx_byte), .flag_set(flag_set),
   .rsp_valid_q(rsp_valid_q), .rsp_status_q(rsp_status_q), .rsp_instr_q(rsp_instr_q),
   .rsp_value_q(rsp_value_q), .err_flags_q(err_flags_q), .accu_q(accu_q));

/* test_accu_x_with_constant_a_and_transfer.sv */
`timescale 1ns/100ps
`include "axc_cfg.svh"
`define AXC_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_accu_x_with_constant_a_and_transfer;
   typedef struct packed {logic [7:0] ins, typ, bnk; logic [31:0] acc, xr, ea, ex;
      logic [7:0] st;} axc_row_t;
   logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0, bus_rdata_q, d;
   logic [4:0] flag_set = 5'h00, err_flags_q, ef;
   logic rx_valid, rsp_valid_q, irq_q;
   axc_pkg::axc_byte_t rx_byte, rsp_module_q, rsp_status_q, rsp_instr_q;
   axc_pkg::axc_word_t rsp_value_q, accu_q;
   axc_row_t r;
   logic [1:0] pa;
   int num_errors = 0, comparisons = 0, cycles = 0;
   axc_row_t rows[$] = '{
      '{8'h21, 8'h00, 8'h07, 32'h5, 32'h3, 32'h8, 32'h3, 8'h64},
      '{8'h21, 8'h01, 8'h07, 32'h5, 32'h3, 32'h2, 32'h3, 8'h64},
      '{8'h21, 8'h02, 8'h07, 32'hfffffff9, 32'h3, 32'hffffffeb, 32'h3, 8'h64},
      '{8'h21, 8'h03, 8'h07, 32'hfffffff9, 32'h2, 32'hfffffffd, 32'h2, 8'h64},
      '{8'h21, 8'h04, 8'h07, 32'hfffffff9, 32'h2, 32'hffffffff, 32'h2, 8'h64},
      '{8'h21, 8'h05, 8'h07, 32'hf0f0, 32'hff00, 32'hf000, 32'hff00, 8'h64},
      '{8'h21, 8'h06, 8'h07, 32'hf0f0, 32'hff00, 32'hfff0, 32'hff00, 8'h64},
      '{8'h21, 8'h07, 8'h07, 32'hf0f0, 32'hff00, 32'h0ff0, 32'hff00, 8'h64},
      '{8'h21, 8'h08, 8'h07, 32'hf0f0, 32'hff00, 32'hffff00ff, 32'hff00, 8'h64},
      '{8'h21, 8'h09, 8'h07, 32'h5, 32'h3, 32'h5, 32'h5, 8'h64},
      '{8'h21, 8'h0a, 8'h07, 32'h5, 32'h3, 32'h3, 32'h5, 8'h64},
      '{8'h21, 8'h0b, 8'h07, 32'h5, 32'h3, 32'h5, 32'h3, 8'h03},
      '{8'h21, 8'h03, 8'h07, 32'h5, 32'h0, 32'h5, 32'h0, 8'h04},
      '{8'h22, 8'h05, 8'h00, 32'h1234, 32'h0, 32'h1234, 32'h0, 8'h64},
      '{8'h22, 8'h05, 8'h01, 32'h1234, 32'h0, 32'h1234, 32'h0, 8'h04},
      '{8'h23, 8'h2a, 8'h02, 32'h4321, 32'h0, 32'h4321, 32'h0, 8'h64},
      '{8'h23, 8'h10, 8'h00, 32'h55aa, 32'h0, 32'h55aa, 32'h0, 8'h64},
      '{8'h23, 8'h11, 8'h03, 32'haa55, 32'h0, 32'haa55, 32'h0, 8'h64},
      '{8'h23, 8'h11, 8'h01, 32'haa55, 32'h0, 32'haa55, 32'h0, 8'h04},
      '{8'h24, 8'h00, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h01, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h02, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h03, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h04, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h05, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h64},
      '{8'h24, 8'h06, 8'h07, 32'h9, 32'h4, 32'h9, 32'h4, 8'h03},
      '{8'h30, 8'h00, 8'h00, 32'h9, 32'h4, 32'h9, 32'h4, 8'h02}};
   axc_top axc_top_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .flag_set(flag_set), .rsp_valid_q(rsp_valid_q),
      .rsp_module_q(rsp_module_q), .rsp_status_q(rsp_status_q), .rsp_instr_q(rsp_instr_q),
      .rsp_value_q(rsp_value_q), .err_flags_q(err_flags_q), .accu_q(accu_q), .irq_q(irq_q));
   axc_host_model axc_host_model_i (.mclk(mclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
   always #4 mclk = ~mclk;
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata_q;
   endtask
   task automatic frame(input logic [7:0] a, i, t);
      axc_host_model_i.send(a, i, t, 8'h07, 32'h1234_5678, 1'b0);
      @(posedge mclk);
      #1;
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      rd(`AXC_REG_CTRL);
      `AXC_CHK(d, `AXC_CTRL_RESET)
      `AXC_CHK(accu_q, 32'h0)
      foreach (rows[n]) begin
         r = rows[n];
         wr(`AXC_REG_ACCU, r.acc);
         wr(`AXC_REG_XREG, r.xr);
         @(posedge mclk) flag_set <= 5'h1f;
         @(posedge mclk) flag_set <= 5'h00;
         axc_host_model_i.send(8'h01, r.ins, r.typ, r.bnk, 32'h1234_5678, 1'b0);
         @(posedge mclk);
         #1;
         `AXC_CHK(rsp_valid_q, 1'b1)
         `AXC_CHK(rsp_status_q, r.st)
         `AXC_CHK(rsp_instr_q, r.ins)
         `AXC_CHK(rsp_module_q, 8'h01)
         `AXC_CHK(rsp_value_q, 32'h0)
         `AXC_CHK(accu_q, r.ea)
         ef = (r.ins == 8'h24 && r.st == 8'h64) ?
              ((r.typ == 8'h00) ? 5'h00 : 5'h1f & ~(5'h01 << (r.typ - 8'h01))) : 5'h1f;
         `AXC_CHK(err_flags_q, ef)
         rd(`AXC_REG_XREG);
         `AXC_CHK(d, r.ex)
         if (r.st == 8'h64 && r.ins inside {8'h22, 8'h23}) begin
            pa = (r.ins == 8'h22) ? 2'h0 : ((r.bnk == 8'h00) ? 2'h1 : r.bnk[1:0]);
            wr(`AXC_REG_PARAM_ADDR, {22'h0, pa, r.typ});
            rd(`AXC_REG_PARAM_DATA);
            `AXC_CHK(d, r.acc)
         end
      end
      rd(`AXC_REG_ERRFLAGS);
      `AXC_CHK(d, 32'h1f)
      axc_host_model_i.send(8'h01, 8'h21, 8'h00, 8'h00, 32'h0, 1'b1);
      @(posedge mclk);
      #1;
      `AXC_CHK(rsp_status_q, `AXC_ST_BAD_CSUM)
      `AXC_CHK(accu_q, 32'h9)
      // Done, checksum, reject and flag events have all been seen by now.
      rd(`AXC_REG_IRQ_STATUS);
      `AXC_CHK(d, 32'hf)
      frame(8'h02, 8'h21, 8'h00);
      `AXC_CHK(rsp_valid_q, 1'b0)
      // Two swaps sent back to back must leave both registers as they were.
      axc_host_model_i.send(8'h01, 8'h21, 8'h0a, 8'h00, 32'h0, 1'b0);
      frame(8'h01, 8'h21, 8'h0a);
      `AXC_CHK(accu_q, 32'h9)
      wr(`AXC_REG_IRQ_CLEAR, 32'hf);
      wr(`AXC_REG_IRQ_ENABLE, 32'h1);
      `AXC_CHK(irq_q, 1'b0)
      frame(8'h01, 8'h21, 8'h00);
      @(posedge mclk);
      #1;
      `AXC_CHK(irq_q, 1'b1)
      wr(`AXC_REG_IRQ_ENABLE, 32'h0);
      @(posedge mclk);
      #1;
      `AXC_CHK(irq_q, 1'b0)
      wr(`AXC_REG_IRQ_ENABLE, 32'h1);
      wr(`AXC_REG_IRQ_CLEAR, 32'h1);
      @(posedge mclk);
      #1;
      `AXC_CHK(irq_q, 1'b0)
      rd(8'h40);
      `AXC_CHK(d, 32'h0)
      wr(`AXC_REG_CTRL, 32'h0000_0100);
      frame(8'h01, 8'h21, 8'h00);
      `AXC_CHK(rsp_valid_q, 1'b0)
      `AXC_CHK(accu_q, 32'h11)
      // A write while the clock enable is low must not land.
      @(posedge mclk) ce <= 1'b0;
      wr(`AXC_REG_ACCU, 32'h77);
      ce <= 1'b1;
      rd(`AXC_REG_ACCU);
      `AXC_CHK(d, 32'h11)
      @(posedge mclk) rst_b <= 1'b0;
      @(posedge mclk);
      #1;
      `AXC_CHK(accu_q, 32'h0)
      @(posedge mclk) rst_b <= 1'b1;
      rd(`AXC_REG_CTRL);
      `AXC_CHK(d, `AXC_CTRL_RESET)
      give_verdict();
   end
endmodule
